// [bench/far_side_model.sv]
// far side: runs test steps on request and holds the retained restart-cause store
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] lat,
  input wire logic [4:0] fail_code,
  input wire logic step_req,
  input wire logic [4:0] step_code,
  output logic step_done,
  output logic step_ok,
  input wire logic keep_we,
  input wire logic keep_valid,
  input wire logic [4:0] keep_code,
  output logic kept_valid,
  output logic [4:0] kept_code
);
  logic [7:0] wait_q;

  // store ignores presetn: it stands for battery-backed memory
  initial begin
    kept_valid = 1'b0;
    kept_code = 5'h00;
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_done <= 1'b0;
      step_ok <= 1'b0;
      wait_q <= 8'h00;
    end else if (step_req && !step_done && wait_q >= lat) begin
      step_done <= 1'b1;
      step_ok <= (step_code != fail_code);
      wait_q <= 8'h00;
    end else begin
      step_done <= 1'b0;
      // verdict line is meaningless off the done cycle, so it wanders
      step_ok <= ~step_ok;
      wait_q <= (step_req && !step_done) ? wait_q + 8'h01 : 8'h00;
    end
  end

  always @(posedge pclk) begin
    if (keep_we) begin
      kept_valid <= keep_valid;
      kept_code <= keep_code;
    end
  end
endmodule
`default_nettype wire

// [bench/selftest_supervisor_props.sv]
// concurrent checks on the self-test supervisor ports
`timescale 1ns/10ps
`default_nettype none
module selftest_supervisor_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic step_req,
  input wire logic [4:0] step_code,
  input wire logic step_done,
  input wire logic step_ok,
  input wire logic rec_valid,
  input wire logic [4:0] rec_code,
  input wire logic rec_ready,
  input wire logic keep_we,
  input wire logic keep_valid,
  input wire logic [4:0] keep_code,
  input wire logic batt_ok,
  input wire logic healthy_led,
  input wire logic wdog_contact,
  input wire logic prot_en,
  input wire logic net_reset
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_LED_TIES: assert property (wdog_contact == !healthy_led && prot_en == healthy_led)
    else $error("contact or protection not tied to led");
  AST_REBOOT_DARK: assert property (
    keep_we && keep_valid |=> (!healthy_led && wdog_contact) [*8])
    else $error("led on during reboot");
  AST_SVC_ENTRY: assert property (
    $rose(healthy_led) |-> $past(step_req && step_done && step_ok && step_code == 5'h11))
    else $error("service entered without last step passing");
  AST_STEP_HOLD: assert property (
    step_req && !step_done && !healthy_led && !$past(healthy_led) |=> step_req && $stable(step_code))
    else $error("step request dropped early");
  AST_REC_HOLD: assert property (
    rec_valid && !rec_ready |=> rec_valid && $stable(rec_code))
    else $error("record lost while stalled");
  AST_FAIL_REC: assert property (
    step_req && step_done && !step_ok && !rec_valid |=> rec_valid && rec_code == $past(step_code))
    else $error("failed step not recorded");
  AST_KEEP_CAUSE: assert property (
    healthy_led && step_req && step_done && !step_ok && step_code != 5'h0f
    |=> keep_we && keep_valid && keep_code == $past(step_code))
    else $error("restart cause not kept");
  AST_BATT_RUN: assert property ($fell(batt_ok) && healthy_led |=> healthy_led [*8])
    else $error("battery fault left service");
  AST_NET_RST: assert property (net_reset |-> healthy_led ##1 !net_reset [*8])
    else $error("network reset outside service or too often");
  AST_UNMAPPED: assert property (psel && penable && paddr > 12'h00c |-> pready && pslverr)
    else $error("unmapped access not refused");
endmodule

bind selftest_supervisor selftest_supervisor_props i_props (.pclk, .presetn, .psel, .penable,
  .paddr, .pready, .pslverr, .step_req, .step_code, .step_done, .step_ok, .rec_valid, .rec_code,
  .rec_ready, .keep_we, .keep_valid, .keep_code, .batt_ok, .healthy_led, .wdog_contact, .prot_en,
  .net_reset);
`default_nettype wire

// [bench/testbench.sv]
// testbench of the self-test supervisor: boot order, fault policy and registers
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seen = 32'h0;
  logic pready, pslverr, er, step_req, step_done, step_ok, rec_valid, keep_we, keep_valid;
  logic [4:0] step_code, rec_code, keep_code, kept_code, fail_code = 5'h00;
  logic kept_valid, healthy_led, wdog_contact, prot_en, net_reset;
  logic rec_ready = 1'b1, batt_ok = 1'b1, field_ok = 1'b1, nvm_access = 1'b0, acq_run = 1'b0;
  logic irig_read = 1'b0, net_alive = 1'b0, net_seen = 1'b0;
  logic [7:0] lat = 8'h00;
  logic [4:0] seq[$];
  int failures = 0, num_checks = 0;

  always #4 pclk = ~pclk;

  selftest_supervisor #(.RESTART_LIMIT_CYC(2000), .NET_TIMEOUT_CYC(50), .CHECK_PERIOD_CYC(40))
    i_dut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf),
    .prdata, .pready, .pslverr, .step_req, .step_code, .step_done, .step_ok, .rec_valid, .rec_code,
    .rec_ready, .keep_we, .keep_valid, .keep_code, .kept_valid, .kept_code, .batt_ok, .field_ok,
    .nvm_access, .acq_run, .irig_read, .net_alive, .healthy_led, .wdog_contact, .prot_en,
    .net_reset);
  far_side_model i_far (.pclk, .presetn, .lat, .fail_code, .step_req, .step_code, .step_done,
    .step_ok, .keep_we, .keep_valid, .keep_code, .kept_valid, .kept_code);

  // sticky capture: the board reset is a single-cycle pulse
  always @(posedge pclk) begin
    if (net_reset) net_seen <= 1'b1;
  end

  always @(posedge pclk) begin
    if (step_req && step_done) begin
      if (healthy_led) seen <= seen | (32'h1 << step_code);
      else seq.push_back(step_code);
    end
  end

  task automatic tally_and_finish();
    if (failures == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] m, e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd & m);
  endtask

  task automatic wait_led(input logic v, input int mx);
    int n;
    n = 0;
    while (healthy_led !== v && n < mx) begin
      @(posedge pclk);
      n++;
    end
    chk("healthy_led", 32'(v), 32'(healthy_led));
    if (healthy_led !== v) tally_and_finish();
  endtask

  task automatic chk_boot();
    int k;
    k = 0;
    for (int c = 1; c <= 17; c++) begin
      if (c != 15) begin
        chk("boot_step", 32'(c), 32'(seq[k]));
        k++;
      end
    end
    chk("boot_len", 32'(k), 32'(seq.size()));
  endtask

  initial begin
    tick(5);
    presetn <= 1'b1;
    rdc("ctrl", 12'h000, 32'hf, 32'h8);
    chk("boot_contact", 32'h1, 32'(wdog_contact));
    wait_led(1'b1, 3000);
    chk_boot();
    chk("prot_en", 32'h1, 32'(prot_en));
    rdc("status", 12'h004, 32'hf, 32'h9);
    apb(1'b0, 12'h010, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    chk("rd_unmapped", 32'h0, rd);
    rec_ready <= 1'b0;
    batt_ok <= 1'b0;
    tick(20);
    chk("batt_led", 32'h1, 32'(healthy_led));
    chk("batt_rec", 32'h108, 32'({rec_valid, 3'h0, rec_code}));
    rec_ready <= 1'b1;
    rdc("alarm_batt", 12'h008, 32'h2, 32'h2);
    apb(1'b1, 12'h008, 32'h2);
    rdc("alarm_clr", 12'h008, 32'h2, 32'h0);
    batt_ok <= 1'b1;
    apb(1'b1, 12'h000, 32'ha);
    nvm_access <= 1'b1;
    acq_run <= 1'b1;
    irig_read <= 1'b1;
    tick(1);
    nvm_access <= 1'b0;
    acq_run <= 1'b0;
    irig_read <= 1'b0;
    tick(100);
    chk("svc_checks", 32'h7a00a, seen & 32'h7a00a);
    fail_code <= 5'h0f;
    irig_read <= 1'b1;
    tick(1);
    irig_read <= 1'b0;
    tick(20);
    chk("irig_led", 32'h1, 32'(healthy_led));
    rdc("alarm_irig", 12'h008, 32'h4, 32'h4);
    fail_code <= 5'h00;
    apb(1'b1, 12'h000, 32'hc);
    repeat (6) begin
      net_alive <= 1'b1;
      tick(1);
      net_alive <= 1'b0;
      tick(20);
    end
    rdc("alarm_live", 12'h008, 32'h1, 32'h0);
    tick(60);
    rdc("alarm_net", 12'h008, 32'h1, 32'h1);
    chk("net_reset", 32'h1, 32'(net_seen));
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h008, 32'hf);
    fail_code <= 5'h03;
    wait_led(1'b0, 200);
    tick(400);
    rdc("status_out", 12'h004, 32'hf, 32'h4);
    chk("kept", 32'h23, 32'({kept_valid, kept_code}));
    fail_code <= 5'h05;
    presetn <= 1'b0;
    tick(5);
    presetn <= 1'b1;
    tick(200);
    rdc("status_hold", 12'h004, 32'h3f000f, 32'h230003);
    fail_code <= 5'h00;
    tick(100);
    chk("hold_contact", 32'h1, 32'(wdog_contact));
    lat <= 8'd20;
    apb(1'b1, 12'h000, 32'h9);
    wait_led(1'b1, 3000);
    field_ok <= 1'b0;
    wait_led(1'b0, 50);
    field_ok <= 1'b1;
    wait_led(1'b1, 3000);
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [src/check_arbiter.sv]
// pending flags for continuous checks with a lowest-index-first grant
`timescale 1ns/10ps
`default_nettype none
module check_arbiter #(
  parameter int N = 7
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [N-1:0] set_vec,
  input wire logic take,
  output logic [N-1:0] pend,
  output logic [N-1:0] grant,
  output logic any
);
  typedef struct packed {
    logic [N-1:0] pend;
  } arb_st_t;
  arb_st_t q, d;
  logic [N:0] above;

  assign above[0] = 1'b0;
  for (genvar i = 0; i < N; i++) begin : g_bit
    assign above[i+1] = above[i] | q.pend[i];
    assign grant[i] = q.pend[i] & ~above[i];
  end

  // a request arriving while its flag is taken stays pending
  always_comb begin
    d = q;
    d.pend = set_vec | (q.pend & ~(take ? grant : {N{1'b0}}));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign pend = q.pend;
  assign any = above[N];
endmodule
`default_nettype wire

// [src/cycle_timer.sv]
// free-running period timer that pulses once per COUNT cycles while run is high
`timescale 1ns/10ps
`default_nettype none
module cycle_timer #(
  parameter int unsigned COUNT = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  input wire logic restart,
  output logic expired
);
  selftest_pkg::timer_st_t q, d;

  always_comb begin
    d = q;
    d.expired = 1'b0;
    if (!run || restart) begin
      d.cnt = 32'h0;
    end else if (q.cnt >= COUNT - 1) begin
      d.cnt = 32'h0;
      d.expired = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  assign expired = q.expired;
endmodule
`default_nettype wire

// [src/selftest_consts.svh]
// register offsets, field positions, reset values and timing counts of the self-test supervisor
`ifndef SELFTEST_CONSTS_SVH
`define SELFTEST_CONSTS_SVH

`define ST_OFF_CTRL 12'h000
`define ST_OFF_STATUS 12'h004
`define ST_OFF_ALARM 12'h008
`define ST_OFF_PEND 12'h00c

`define ST_CTRL_RESTORE 0
`define ST_CTRL_IRIG 1
`define ST_CTRL_NET 2
`define ST_CTRL_CONT 3
`define ST_CTRL_CONT_RST 1'b1

`define ST_ALM_NET 0
`define ST_ALM_BATT 1
`define ST_ALM_IRIG 2
`define ST_ALM_LOST 3

`define ST_BOOT_LAST 5'h10
`define ST_NUM_CONT 7

`define ST_CLK_HZ 125000000
`define ST_RESTART_LIMIT_S 12
`define ST_NET_TIMEOUT_MS 10
`define ST_CHECK_PERIOD_US 1000
`define ST_REBOOT_HOLD_NS 1000
`define ST_RESTART_LIMIT_CYC (`ST_RESTART_LIMIT_S * `ST_CLK_HZ)
`define ST_NET_TIMEOUT_CYC (`ST_NET_TIMEOUT_MS * (`ST_CLK_HZ / 1000))
`define ST_CHECK_PERIOD_CYC (`ST_CHECK_PERIOD_US * (`ST_CLK_HZ / 1000000))
`define ST_REBOOT_HOLD_CYC ((`ST_REBOOT_HOLD_NS * (`ST_CLK_HZ / 1000000)) / 1000)

`endif

// [src/selftest_pkg.sv]
// types shared by the self-test supervisor modules
package selftest_pkg;

  typedef enum logic [4:0] {
    T_NONE, T_FLASH_SUM, T_COPY, T_SRAM_CMP, T_CPU_INIT, T_WDOG_START, T_OS_START,
    T_SUP_TASK, T_BATT, T_RECMEM, T_FIELD, T_LCD, T_WDOG, T_NVM, T_RTC, T_IRIG,
    T_INBOARD, T_REFV, T_SRAM_SUM, T_NET
  } step_t;

  typedef enum logic [2:0] {S_BOOT, S_SERVICE, S_REBOOT, S_HOLD, S_OUT} mode_t;

  typedef struct packed {
    logic [31:0] cnt;
    logic expired;
  } timer_st_t;

  typedef struct packed {
    mode_t mode;
    logic [4:0] idx;
    logic busy;
    step_t code;
    logic restarted;
    logic [7:0] hold;
    logic init;
    logic ref_valid;
    step_t ref_code;
    step_t last_fault;
    logic irig_fit;
    logic net_fit;
    logic cont_en;
    logic [3:0] alarm;
    logic rec_valid;
    step_t rec_code;
    logic keep_we;
    logic keep_valid;
    step_t keep_code;
    logic net_reset;
    logic batt_prev;
    logic [31:0] prdata;
  } sup_st_t;

endpackage

// [src/selftest_supervisor.sv]
// relay self-test supervisor: start-up sequencer, continuous checker and fault policy
// Behaviour
// - reboot: indicator off, watchdog contact active
// - unresolved fault: permanent out of service
// - every detected problem writes maintenance record; a full slot only sets the loss alarm, restart time-out writes none
// - checksum flash before copy and start
// - compare sram with flash before entry
// - init: cpu, watchdogs, os, supervisor task
// - check battery, record memory, field, display, watchdog
// - checksum nvm, test clock, irig if fitted
// - last: input board and reference voltage
// - service and protection only after all pass
// - start-up failure holds until manual restore
// - in service: flash checksum, sram code compare
// - in service: sram data sum, battery, field
// - nvm settings checksum on every access
// - each acquisition run: digital io, reference
// - irig checked on each time read
// - network silent: alarm and reset board
// - battery or irig fault: log, keep running
// - other faults restart, at most 12 s
// - same fault after restart: permanent out
`timescale 1ns/10ps
`default_nettype none
`include "selftest_consts.svh"
module selftest_supervisor #(
  parameter int unsigned RESTART_LIMIT_CYC = `ST_RESTART_LIMIT_CYC,
  parameter int unsigned NET_TIMEOUT_CYC = `ST_NET_TIMEOUT_CYC,
  parameter int unsigned CHECK_PERIOD_CYC = `ST_CHECK_PERIOD_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic step_req,
  output logic [4:0] step_code,
  input wire logic step_done,
  input wire logic step_ok,
  output logic rec_valid,
  output logic [4:0] rec_code,
  input wire logic rec_ready,
  output logic keep_we,
  output logic keep_valid,
  output logic [4:0] keep_code,
  input wire logic kept_valid,
  input wire logic [4:0] kept_code,
  input wire logic batt_ok,
  input wire logic field_ok,
  input wire logic nvm_access,
  input wire logic acq_run,
  input wire logic irig_read,
  input wire logic net_alive,
  output logic healthy_led,
  output logic wdog_contact,
  output logic prot_en,
  output logic net_reset
);
  import selftest_pkg::*;

  sup_st_t q, d;
  logic chk_tick, net_exp, lim_exp, take, arb_any;
  logic [`ST_NUM_CONT-1:0] set_vec, pend, grant;
  logic in_service, wr, rd_setup, mapped;

  // fixed start-up order; the irig entry is skipped when no board is fitted
  function automatic step_t boot_step(input logic [4:0] i);
    case (i)
      5'h00: boot_step = T_FLASH_SUM;
      5'h01: boot_step = T_COPY;
      5'h02: boot_step = T_SRAM_CMP;
      5'h03: boot_step = T_CPU_INIT;
      5'h04: boot_step = T_WDOG_START;
      5'h05: boot_step = T_OS_START;
      5'h06: boot_step = T_SUP_TASK;
      5'h07: boot_step = T_BATT;
      5'h08: boot_step = T_RECMEM;
      5'h09: boot_step = T_FIELD;
      5'h0a: boot_step = T_LCD;
      5'h0b: boot_step = T_WDOG;
      5'h0c: boot_step = T_NVM;
      5'h0d: boot_step = T_RTC;
      5'h0e: boot_step = T_IRIG;
      5'h0f: boot_step = T_INBOARD;
      default: boot_step = T_REFV;
    endcase
  endfunction

  function automatic step_t cont_step(input logic [`ST_NUM_CONT-1:0] g);
    cont_step = T_NONE;
    if (g[0]) cont_step = T_FLASH_SUM;
    if (g[1]) cont_step = T_SRAM_CMP;
    if (g[2]) cont_step = T_SRAM_SUM;
    if (g[3]) cont_step = T_NVM;
    if (g[4]) cont_step = T_INBOARD;
    if (g[5]) cont_step = T_REFV;
    if (g[6]) cont_step = T_IRIG;
  endfunction

  assign in_service = (q.mode == S_SERVICE);
  assign wr = psel && penable && pwrite && pstrb[0];
  assign rd_setup = psel && !penable;
  assign mapped = (paddr == `ST_OFF_CTRL) || (paddr == `ST_OFF_STATUS) ||
                  (paddr == `ST_OFF_ALARM) || (paddr == `ST_OFF_PEND);

  // periodic checks only run while in service with checking enabled
  assign set_vec[0] = chk_tick && q.cont_en;
  assign set_vec[1] = chk_tick && q.cont_en;
  assign set_vec[2] = chk_tick && q.cont_en;
  assign set_vec[3] = nvm_access && in_service;
  assign set_vec[4] = acq_run && in_service;
  assign set_vec[5] = acq_run && in_service;
  assign set_vec[6] = irig_read && in_service && q.irig_fit;

  cycle_timer #(.COUNT(CHECK_PERIOD_CYC)) u_chk_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(in_service),
    .restart(1'b0),
    .expired(chk_tick)
  );

  // any heartbeat from the network board restarts its silence timer
  cycle_timer #(.COUNT(NET_TIMEOUT_CYC)) u_net_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(in_service && q.net_fit),
    .restart(net_alive),
    .expired(net_exp)
  );

  // bounds the protection gap of a fault restart
  cycle_timer #(.COUNT(RESTART_LIMIT_CYC)) u_lim_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(q.restarted && (q.mode == S_BOOT || q.mode == S_REBOOT)),
    .restart(1'b0),
    .expired(lim_exp)
  );

  check_arbiter #(.N(`ST_NUM_CONT)) u_arb (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .set_vec(set_vec),
    .take(take),
    .pend(pend),
    .grant(grant),
    .any(arb_any)
  );

  always_comb begin
    logic log_f, log_b, log_n, fault, restore;
    logic [1:0] nlog;
    step_t lc, fcode;
    d = q;
    log_f = 1'b0;
    log_b = 1'b0;
    log_n = 1'b0;
    fault = 1'b0;
    restore = 1'b0;
    nlog = 2'h0;
    lc = q.code;
    fcode = q.code;
    take = 1'b0;
    d.keep_we = 1'b0;
    d.net_reset = 1'b0;
    d.batt_prev = batt_ok;
    if (q.rec_valid && rec_ready) begin
      d.rec_valid = 1'b0;
    end
    // register writes; alarm clears come first so a same-cycle event wins
    if (wr && paddr == `ST_OFF_CTRL) begin
      restore = pwdata[`ST_CTRL_RESTORE];
      d.irig_fit = pwdata[`ST_CTRL_IRIG];
      d.net_fit = pwdata[`ST_CTRL_NET];
      d.cont_en = pwdata[`ST_CTRL_CONT];
    end
    if (wr && paddr == `ST_OFF_ALARM) begin
      d.alarm = q.alarm & ~pwdata[3:0];
    end
    // restart cause is picked up once, after release from power-on reset
    if (q.init) begin
      d.init = 1'b0;
      d.ref_valid = kept_valid;
      d.ref_code = step_t'(kept_code);
    end
    case (q.mode)
      S_BOOT: begin
        if (q.init) begin
          d.idx = 5'h00;
        end else if (!q.busy) begin
          if (boot_step(q.idx) == T_IRIG && !q.irig_fit) begin
            d.idx = q.idx + 5'h01;
          end else begin
            d.busy = 1'b1;
            d.code = boot_step(q.idx);
          end
        end else if (step_done) begin
          d.busy = 1'b0;
          if (step_ok) begin
            if (q.idx == `ST_BOOT_LAST) begin
              d.mode = S_SERVICE;
              d.restarted = 1'b0;
              d.ref_valid = 1'b0;
              d.keep_we = 1'b1;
              d.keep_valid = 1'b0;
            end else begin
              d.idx = q.idx + 5'h01;
            end
          end else begin
            log_f = 1'b1;
            d.last_fault = q.code;
            if (q.ref_valid && q.code == q.ref_code) begin
              d.mode = S_OUT;
            end else begin
              d.mode = S_HOLD;
            end
          end
        end
        if (lim_exp) begin
          d.mode = S_OUT;
          d.busy = 1'b0;
        end
      end
      S_SERVICE: begin
        if (!q.busy && q.cont_en && arb_any) begin
          take = 1'b1;
          d.busy = 1'b1;
          d.code = cont_step(grant);
        end else if (q.busy && step_done) begin
          d.busy = 1'b0;
          if (!step_ok) begin
            if (q.code == T_IRIG) begin
              log_f = 1'b1;
              d.alarm[`ST_ALM_IRIG] = 1'b1;
            end else begin
              fault = 1'b1;
            end
          end
        end
        if (!field_ok && !fault) begin
          fault = 1'b1;
          fcode = T_FIELD;
        end
        if (q.batt_prev && !batt_ok) begin
          log_b = 1'b1;
          d.alarm[`ST_ALM_BATT] = 1'b1;
        end
        if (net_exp) begin
          log_n = 1'b1;
          d.alarm[`ST_ALM_NET] = 1'b1;
          d.net_reset = 1'b1;
        end
        if (fault) begin
          log_f = 1'b1;
          lc = fcode;
          d.last_fault = fcode;
          d.keep_we = 1'b1;
          d.keep_valid = 1'b1;
          d.keep_code = fcode;
          d.ref_valid = 1'b1;
          d.ref_code = fcode;
          d.restarted = 1'b1;
          d.mode = S_REBOOT;
          d.hold = 8'h00;
          d.busy = 1'b0;
        end
      end
      S_REBOOT: begin
        if (lim_exp) begin
          d.mode = S_OUT;
        end else if (q.hold >= 8'(`ST_REBOOT_HOLD_CYC - 1)) begin
          d.mode = S_BOOT;
          d.idx = 5'h00;
        end else begin
          d.hold = q.hold + 8'h01;
        end
      end
      S_HOLD: begin
        if (restore) begin
          d.mode = S_BOOT;
          d.idx = 5'h00;
          d.busy = 1'b0;
        end
      end
      S_OUT: begin
        d.busy = 1'b0;
      end
      default: begin
        d.mode = S_OUT;
      end
    endcase
    // one record slot; extra records in a cycle or while full mark a loss
    nlog = {1'b0, log_f} + {1'b0, log_b} + {1'b0, log_n};
    if (nlog != 2'h0) begin
      if (d.rec_valid || nlog > 2'h1) begin
        d.alarm[`ST_ALM_LOST] = 1'b1;
      end
      if (!d.rec_valid) begin
        d.rec_valid = 1'b1;
        d.rec_code = log_f ? lc : (log_b ? T_BATT : T_NET);
      end
    end
    // read data is captured in the setup phase so the access phase needs no wait
    if (rd_setup) begin
      case (paddr)
        `ST_OFF_CTRL: d.prdata = {28'h0, q.cont_en, q.net_fit, q.irig_fit, 1'b0};
        `ST_OFF_STATUS: d.prdata = {10'h0, q.ref_valid, q.ref_code, 3'h0, q.last_fault,
                                    3'h0, q.busy, in_service, q.mode};
        `ST_OFF_ALARM: d.prdata = {28'h0, q.alarm};
        `ST_OFF_PEND: d.prdata = {25'h0, pend};
        default: d.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.init <= 1'b1;
      q.cont_en <= `ST_CTRL_CONT_RST;
      q.batt_prev <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign step_req = q.busy;
  assign step_code = q.code;
  assign rec_valid = q.rec_valid;
  assign rec_code = q.rec_code;
  assign keep_we = q.keep_we;
  assign keep_valid = q.keep_valid;
  assign keep_code = q.keep_code;
  assign healthy_led = in_service;
  assign prot_en = in_service;
  assign wdog_contact = !in_service;
  assign net_reset = q.net_reset;
endmodule
`default_nettype wire
